//--- design/polen_ctrl.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "polen_cfg.svh"
module polen_ctrl
  import polen_pkg::*;
#(
  parameter int SW_DIV = 100
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              onoff_in,
  input  wire polen_pkg::polen_volt_t vout_meas,
  input  wire logic              fault_in,
  output logic                   pgood_o,
  output logic                   pgood_oe_n,
  output logic                   switch_en,
  output polen_pkg::polen_volt_t vref,
  output logic [7:0]             tune_out,
  output logic                   irq
);
  import polen_pkg::*;
  logic [1:0]  sync_q;
  logic [1:0]  onoff_q, onoff_d;
  logic [3:0]  aggr_q, aggr_d;
  logic        quiet_q, quiet_d;
  logic [1:0]  esr_q, esr_d;
  polen_volt_t setpt_q, setpt_d, win_q, win_d, rate_q, rate_d, thr_q, thr_d;
  logic [31:0] ton_q, ton_d, toff_q, toff_d;
  logic [`POLEN_IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic [31:0] rd_q, rd_d;
  logic        rdy_q, err_q, err_d;
  polen_state_e st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  polen_volt_t ref_q, ref_d, prebias_q, prebias_d;
  logic        sw_q, sw_d, pg_q, pg_d, irq_q, irq_d;
  logic [15:0] div_q, div_d;
  logic        tick;
  logic        want_on, in_win, pg_rise, pg_fall;
  logic [7:0]  tune;
  polen_volt_t lo_lim, hi_lim;
  logic        acc, wr, rd;

  // access completes in the cycle after setup, when the registered ready stands
  assign acc = psel && penable && rdy_q;
  assign wr  = acc && pwrite;
  // read word captured at setup so prdata comes straight from a flop
  assign rd  = psel && !penable && !pwrite;

  // two stages before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sync_q <= 2'b00;
    else
      sync_q <= {sync_q[0], onoff_in};

  always_comb
  begin
    case (polen_onoff_e'(onoff_q))
      POLEN_ONOFF_HIGH: want_on = sync_q[1];
      POLEN_ONOFF_LOW:  want_on = !sync_q[1];
      default:          want_on = 1'b1;
    endcase
  end

  assign tick = (div_q == 16'(SW_DIV - 1));
  assign lo_lim = (setpt_q > win_q) ? setpt_q - win_q : '0;
  assign hi_lim = setpt_q + win_q;
  // window follows the live setpoint
  assign in_win = (vout_meas >= lo_lim) && (vout_meas <= hi_lim);

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    ref_d = ref_q;
    prebias_d = prebias_q;
    sw_d = sw_q;
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
    case (st_q)
      POLEN_OFF:
      begin
        sw_d = 1'b0;
        ref_d = '0;
        cnt_d = '0;
        if (want_on && !fault_in)
        begin
          prebias_d = vout_meas; // capture pre-bias level
          st_d = POLEN_DLY_ON;
        end
      end
      POLEN_DLY_ON:
      begin
        if (!want_on || fault_in)
          st_d = POLEN_OFF;
        else if (cnt_q >= ton_q)
          st_d = POLEN_RAMP;
        else
          cnt_d = cnt_q + 32'h1;
      end
      POLEN_RAMP:
      begin
        if (fault_in)
        begin
          sw_d = 1'b0;
          st_d = POLEN_OFF;
        end
        else if (tick)
        begin
          // monotonic climb, clipped at setpoint; a lowered setpoint does not pull it back here, but POLEN_REG then loads it
          if (ref_q >= setpt_q || setpt_q - ref_q <= rate_q)
          begin
            ref_d = (ref_q >= setpt_q) ? ref_q : setpt_q;
            st_d = POLEN_REG;
          end
          else
            ref_d = ref_q + rate_q;
        end
        if (!fault_in && ref_q >= prebias_q)
          sw_d = 1'b1;
      end
      POLEN_REG:
      begin
        sw_d = 1'b1;
        ref_d = setpt_q;
        cnt_d = '0;
        if (fault_in)
        begin
          sw_d = 1'b0;
          st_d = POLEN_OFF;
        end
        else if (!want_on)
          st_d = POLEN_DLY_OF;
      end
      POLEN_DLY_OF:
      begin
        // faults skip the turn-off delay
        if (fault_in || cnt_q >= toff_q)
        begin
          sw_d = 1'b0;
          st_d = POLEN_OFF;
        end
        else if (want_on)
          st_d = POLEN_REG;
        else
          cnt_d = cnt_q + 32'h1;
      end
      default: st_d = POLEN_OFF;
    endcase
    pg_d = (st_q == POLEN_REG) && in_win && !fault_in;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_q <= POLEN_OFF;
      cnt_q <= '0;
      ref_q <= '0;
      prebias_q <= '0;
      sw_q <= 1'b0;
      pg_q <= 1'b0;
      div_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ref_q <= ref_d;
      prebias_q <= prebias_d;
      sw_q <= sw_d;
      pg_q <= pg_d;
      div_q <= div_d;
    end

  polen_tune u_tune (
    .pclk      (pclk),
    .presetn   (presetn),
    .sw_tick   (tick),
    .active    (sw_q),
    .quiet     (quiet_q),
    .aggr      (aggr_q),
    .esr_mode  (esr_q),
    .vout      (vout_meas),
    .target    (ref_q),
    .trans_thr (thr_q),
    .tune      (tune)
  );

  assign pg_rise = pg_d && !pg_q;
  assign pg_fall = !pg_d && pg_q;

  always_comb
  begin
    onoff_d = onoff_q;
    aggr_d = aggr_q;
    quiet_d = quiet_q;
    esr_d = esr_q;
    setpt_d = setpt_q;
    win_d = win_q;
    rate_d = rate_q;
    thr_d = thr_q;
    ton_d = ton_q;
    toff_d = toff_q;
    ien_d = ien_q;
    ist_d = ist_q;
    err_d = 1'b0;
    rd_d = 32'h0;
    if (wr && paddr == `POLEN_A_IRQ_CLR)
      ist_d = ist_q & ~pwdata[`POLEN_IRQ_W-1:0];
    // set beats clear
    ist_d = ist_d | {fault_in, pg_fall, pg_rise, (st_q == POLEN_RAMP && st_d == POLEN_REG)};
    if (psel)
    begin
      case (paddr)
        `POLEN_A_CTRL:
        begin
          if (wr && pwdata[1:0] != 2'h3)
            onoff_d = pwdata[1:0];
          if (wr)
            quiet_d = pwdata[4];
          if (wr && pwdata[9:8] != 2'h3)
            esr_d = pwdata[9:8];
          rd_d = {22'h0, esr_q, 3'h0, quiet_q, 2'h0, onoff_q};
        end
        `POLEN_A_TUNE:
        begin
          if (wr && pwdata[3:0] >= `POLEN_AGGR_MIN && pwdata[3:0] <= `POLEN_AGGR_MAX)
            aggr_d = pwdata[3:0];
          if (wr)
            thr_d = pwdata[27:16];
          rd_d = {4'h0, thr_q, 12'h0, aggr_q};
        end
        `POLEN_A_SETPT:
        begin
          if (wr) setpt_d = pwdata[11:0];
          rd_d = {20'h0, setpt_q};
        end
        `POLEN_A_WINDOW:
        begin
          if (wr) win_d = pwdata[11:0];
          rd_d = {20'h0, win_q};
        end
        `POLEN_A_TON:
        begin
          if (wr) ton_d = pwdata;
          rd_d = ton_q;
        end
        `POLEN_A_TOFF:
        begin
          if (wr) toff_d = pwdata;
          rd_d = toff_q;
        end
        `POLEN_A_RATE:
        begin
          if (wr) rate_d = pwdata[11:0];
          rd_d = {20'h0, rate_q};
        end
        `POLEN_A_STATUS: rd_d = {16'h0, ref_q, 1'b0, st_q};
        `POLEN_A_IRQ_ST: rd_d = {28'h0, ist_q};
        `POLEN_A_IRQ_EN:
        begin
          if (wr) ien_d = pwdata[`POLEN_IRQ_W-1:0];
          rd_d = {28'h0, ien_q};
        end
        `POLEN_A_IRQ_CLR: rd_d = 32'h0;
        `POLEN_A_TUNE_OUT: rd_d = {24'h0, tune};
        default: err_d = 1'b1;
      endcase
    end
    irq_d = |(ist_d & ien_d);
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      onoff_q <= `POLEN_ONOFF_RST;
      aggr_q <= `POLEN_AGGR_RST;
      quiet_q <= 1'b0;
      esr_q <= `POLEN_ESR_RST;
      setpt_q <= `POLEN_SETPT_RST;
      win_q <= `POLEN_WIN_RST;
      rate_q <= `POLEN_RATE_RST;
      thr_q <= `POLEN_TRANS_RST;
      ton_q <= '0;
      toff_q <= '0;
      ien_q <= '0;
      ist_q <= '0;
      rd_q <= '0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      onoff_q <= onoff_d;
      aggr_q <= aggr_d;
      quiet_q <= quiet_d;
      esr_q <= esr_d;
      setpt_q <= setpt_d;
      win_q <= win_d;
      rate_q <= rate_d;
      thr_q <= thr_d;
      ton_q <= ton_d;
      toff_q <= toff_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      rd_q <= rd ? rd_d : 32'h0;
      rdy_q <= psel && !penable;
      err_q <= err_d && !penable;
      irq_q <= irq_d;
    end

  // answer registered during setup, stands for the single access cycle
  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign pgood_o = 1'b0;
  assign pgood_oe_n = pg_q;
  assign switch_en = sw_q;
  assign vref = ref_q;
  assign tune_out = tune;
  assign irq = irq_q;

  pg_regulation_a: assert property (@(posedge pclk) disable iff (!presetn)
    pgood_oe_n |-> $past(st_q) == POLEN_REG && $past(in_win)) else $error("pg outside regulation");
  pg_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_in |=> !pgood_oe_n) else $error("pg high during fault");
  prebias_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == POLEN_RAMP && ref_q < prebias_q && !sw_q) |=> !sw_q) else $error("early switch");
  aggr_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    aggr_q >= `POLEN_AGGR_MIN && aggr_q <= `POLEN_AGGR_MAX) else $error("aggr range");
  ramp_mono_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == POLEN_RAMP) |=> ref_q >= $past(ref_q)) else $error("ramp not monotonic");
  sync_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync_q[1] == $past(onoff_in, 2) || $past(!presetn, 2)) else $error("sync depth");
  off_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == POLEN_DLY_OF && !fault_in && cnt_q < toff_q && !want_on) |=> sw_q)
    else $error("stopped early");
  force_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (onoff_q == POLEN_ONOFF_NONE && st_q == POLEN_REG && !fault_in) |=> st_q == POLEN_REG)
    else $error("ignored mode");
  cover_ramp_c: cover property (@(posedge pclk) st_q == POLEN_RAMP ##1 st_q == POLEN_REG);
  cover_off_c: cover property (@(posedge pclk) st_q == POLEN_DLY_OF ##1 st_q == POLEN_OFF);
  cover_pg_c: cover property (@(posedge pclk) pgood_oe_n);
endmodule : polen_ctrl

//--- design/polen_tune.sv
`timescale 1ns/1ps
`include "polen_cfg.svh"
module polen_tune
  import polen_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              sw_tick,
  input  wire logic              active,
  input  wire logic              quiet,
  input  wire logic [3:0]        aggr,
  input  wire logic [1:0]        esr_mode,
  input  wire polen_pkg::polen_volt_t vout,
  input  wire polen_pkg::polen_volt_t target,
  input  wire polen_pkg::polen_volt_t trans_thr,
  output logic [7:0]             tune
);
  logic [7:0] tune_q, tune_d;
  logic       big_err;
  polen_volt_t err;
  assign tune = tune_q;
  assign err = (vout > target) ? vout - target : target - vout;
  assign big_err = err > trans_thr;
  always_comb
  begin
    tune_d = tune_q;
    if (sw_tick && active)
    begin
      if (quiet)
        tune_d = {2'h0, esr_mode, `POLEN_TUNE_LOW};
      else if (big_err)
        tune_d = {2'h0, esr_mode, `POLEN_TUNE_HIGH};
      else
        tune_d = {2'h0, esr_mode, aggr};
    end
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tune_q <= 8'h00;
    else
      tune_q <= tune_d;
endmodule : polen_tune

//--- include/polen_cfg.svh
// How it works
// - on/off input mode selects active-high, active-low, or ignored (always on).
// - active-high enables output while input high; active-low inverts that.
// - after reset the on/off mode is always on; input has no effect.
// - power-good only while measured output is inside a window around setpoint.
// - power-good drops whenever regulation is lost, including fault conditions.
// - power-good pin only pulls low, otherwise released for external pull-up.
// - on enable, wait start delay, then ramp reference at programmed rate.
// - with pre-bias, switching stays off until reference reaches pre-bias level.
// - aggressiveness level 1 to 9, resets to 5.
// - output measurement re-evaluated each switching cycle to update tuning.
// - low-noise mode keeps tuning at a low value.
// - without low-noise, tuning high during transients, moderate in steady state.
// - lossy capacitor tuning mode off, low or high; resets to off.
// - on/off assertion starts turn-on delay, then monotonic rise to regulation.
// - on/off deassertion starts turn-off delay, regulate, then stop switching.
`ifndef POLEN_CFG_SVH
`define POLEN_CFG_SVH
`define POLEN_A_CTRL      12'h000
`define POLEN_A_TUNE      12'h004
`define POLEN_A_SETPT     12'h008
`define POLEN_A_WINDOW    12'h00c
`define POLEN_A_TON       12'h010
`define POLEN_A_TOFF      12'h014
`define POLEN_A_RATE      12'h018
`define POLEN_A_STATUS    12'h01c
`define POLEN_A_IRQ_ST    12'h020
`define POLEN_A_IRQ_EN    12'h024
`define POLEN_A_IRQ_CLR   12'h028
`define POLEN_A_TUNE_OUT  12'h02c
`define POLEN_ONOFF_RST   2'h2
`define POLEN_AGGR_RST    4'h5
`define POLEN_AGGR_MIN    4'h1
`define POLEN_AGGR_MAX    4'h9
`define POLEN_ESR_RST     2'h0
`define POLEN_SETPT_RST   12'h000
`define POLEN_WIN_RST     12'h010
`define POLEN_RATE_RST    12'h001
`define POLEN_TRANS_RST   12'h020
`define POLEN_TUNE_LOW    4'h1
`define POLEN_TUNE_HIGH   4'h9
`define POLEN_TUNE_STEP   16'h0028
`define POLEN_VW          12
`define POLEN_IRQ_W       4
`endif

//--- include/polen_pkg.sv
package polen_pkg;
  typedef enum logic [1:0] {
    POLEN_ONOFF_HIGH = 2'b00,
    POLEN_ONOFF_LOW  = 2'b01,
    POLEN_ONOFF_NONE = 2'b10
  } polen_onoff_e;
  typedef enum logic [2:0] {
    POLEN_OFF    = 3'b000,
    POLEN_DLY_ON = 3'b001,
    POLEN_RAMP   = 3'b010,
    POLEN_REG    = 3'b011,
    POLEN_DLY_OF = 3'b100
  } polen_state_e;
  typedef logic [11:0] polen_volt_t;
endpackage : polen_pkg

//--- tb/polen_seq_model.sv
`timescale 1ns/1ps
module polen_seq_model
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic req_on,
  input  wire logic pgood_o,
  input  wire logic pgood_oe_n,
  output logic      onoff_in,
  output logic      pg_seen
);
  // board pull-up makes the high level once the pin is released
  assign pg_seen = pgood_oe_n ? 1'b1 : pgood_o;
  // a clocked sequencer: its enable moves only just after an edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      onoff_in <= 1'b0;
    else
      onoff_in <= req_on;
endmodule : polen_seq_model

//--- tb/tb.sv
`timescale 1ns/1ps
`include "polen_cfg.svh"
module tb;
  import polen_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        onoff_in;
  logic        fault_in;
  logic        pgood_o;
  logic        pgood_oe_n;
  logic        switch_en;
  logic        irq;
  logic        req_on;
  logic        pg_seen;
  logic [7:0]  tune_out;
  polen_volt_t vref;
  polen_volt_t vout;
  polen_volt_t bump;
  polen_volt_t pb;
  logic [65:0] rq[$];
  int          fails;
  int          n_compared;
  int          cyc;
  int          seed;

  polen_ctrl #(.SW_DIV(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .onoff_in, .vout_meas(vout), .fault_in,
    .pgood_o, .pgood_oe_n, .switch_en, .vref, .tune_out, .irq);
  polen_seq_model i_seq (.pclk, .presetn, .req_on, .pgood_o, .pgood_oe_n, .onoff_in,
    .pg_seen);

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // crude output stage: follows the reference only while switching
  // off: output sits at the pre-bias level
  always @(posedge pclk)
    vout <= (switch_en === 1'b1) ? vref + bump : pb;

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
      compare_rd(rq.pop_front(), {pslverr, prdata});

  task stop_test();
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task compare_rd(input logic [65:0] e, input logic [32:0] g);
    n_compared++;
    if ((g & e[65:33]) !== e[32:0])
    begin
      fails++;
      $display("MISMATCH apb read exp %h got %h", e[32:0], g);
    end
  endtask : compare_rd

  task compare_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : compare_v

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [65:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    if (!wr)
      rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fails++;
        stop_test();
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 66'h0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {33'h1ffffffff, 1'b0, d});
  endtask : rd

  // 0 switching, 1 power good pin, 2 interrupt, 3 reference left zero
  task wait_on(input int s, input logic v);
    logic g;
    cyc = 0;
    do
    begin
      @(posedge pclk);
      g = (s == 0) ? switch_en : (s == 1) ? pg_seen : (s == 2) ? irq : (vref != 0);
      cyc++;
      if (cyc > 3000)
      begin
        fails++;
        stop_test();
      end
    end while (g !== v);
  endtask : wait_on

  initial
  begin
    #2000000;
    fails++;
    stop_test();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn, req_on, fault_in} = '0;
    {pb, bump, fails, n_compared} = '0;
    seed = 26374;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`POLEN_A_CTRL, 32'h2);
    rd(`POLEN_A_TUNE, {4'h0, `POLEN_TRANS_RST, 12'h0, `POLEN_AGGR_RST});
    apb(1'b0, 12'h030, 32'h0, {33'h100000000, 33'h100000000});
    wr(`POLEN_A_TOFF, 32'd20);
    wr(`POLEN_A_CTRL, 32'h0);
    wait_on(0, 1'b0);
    wr(`POLEN_A_TON, 32'd4);
    wr(`POLEN_A_RATE, 32'h10);
    wr(`POLEN_A_SETPT, 32'h100);
    wr(`POLEN_A_TUNE, 32'h00100007);
    wr(`POLEN_A_IRQ_CLR, 32'hf);
    pb <= 12'h040 + 12'($random(seed) & 32'h7f);
    req_on <= 1'b1;
    wait_on(3, 1'b1);
    compare_v("on delay", 1, cyc > 4);
    compare_v("switch held", 0, switch_en);
    wait_on(0, 1'b1);
    compare_v("ref at prebias", 1, vref >= pb);
    wait_on(1, 1'b1);
    compare_v("in window", 1, vout >= 12'h0f0 && vout <= 12'h110);
    compare_v("pin released", 1, pgood_oe_n);
    repeat (12) @(posedge pclk);
    compare_v("tune steady", 8'h07, tune_out);
    bump <= 12'h020;
    wait_on(1, 1'b0);
    repeat (12) @(posedge pclk);
    compare_v("tune transient", 8'h09, tune_out);
    bump <= 12'h000;
    wait_on(1, 1'b1);
    wr(`POLEN_A_CTRL, 32'h210);
    repeat (12) @(posedge pclk);
    compare_v("tune quiet", 8'h21, tune_out);
    wr(`POLEN_A_CTRL, 32'h310);
    rd(`POLEN_A_CTRL, 32'h210);
    wr(`POLEN_A_TUNE, 32'h0010000a);
    rd(`POLEN_A_TUNE, 32'h00100007);
    wr(`POLEN_A_CTRL, 32'h0);
    fault_in <= 1'b1;
    repeat (5) @(posedge pclk);
    compare_v("fault switch", 0, switch_en);
    compare_v("fault pg", 0, pg_seen);
    compare_v("pin level", 0, pgood_o);
    compare_v("irq masked", 0, irq);
    wr(`POLEN_A_IRQ_EN, 32'h8);
    wait_on(2, 1'b1);
    rd(`POLEN_A_IRQ_ST, 32'hf);
    fault_in <= 1'b0;
    wr(`POLEN_A_IRQ_CLR, 32'hf);
    wait_on(2, 1'b0);
    wait_on(1, 1'b1);
    req_on <= 1'b0;
    repeat (12) @(posedge pclk);
    compare_v("off delay", 1, switch_en);
    wait_on(0, 1'b0);
    wr(`POLEN_A_CTRL, 32'h1);
    wait_on(0, 1'b1);
    req_on <= 1'b1;
    wait_on(0, 1'b0);
    wr(`POLEN_A_CTRL, 32'h2);
    wait_on(0, 1'b1);
    req_on <= 1'b0;
    repeat (40) @(posedge pclk);
    compare_v("pin ignored", 1, switch_en);
    stop_test();
  end
endmodule : tb
